// >>> verilog/conv_regs_pkg.sv
// Package: register map, field layouts and constants for the converter bank
`default_nettype none
package conv_regs_pkg;
  localparam logic [7:0] ADDR_FILL_COUNT = 8'h01;
  localparam logic [7:0] ADDR_TALLY = 8'h02;
  localparam logic [7:0] ADDR_C0_LOW = 8'h08;
  localparam logic [7:0] ADDR_C0_HIGH = 8'h09;
  localparam logic [7:0] ADDR_C1_LOW = 8'h0A;
  localparam logic [7:0] ADDR_C1_HIGH = 8'h0B;
  localparam logic [7:0] ADDR_OSC_CHOICE = 8'h18;
  localparam logic [7:0] ADDR_SEQ_KICK = 8'h1E;
  localparam logic [7:0] ADDR_CYCLE_CLK = 8'h19;
  localparam logic [7:0] ADDR_WORD_LAYOUT = 8'h28;
  localparam logic [7:0] ADDR_FILL_POLICY = 8'h2C;
  localparam logic [7:0] ADDR_SUM_ENABLE = 8'h30;

  localparam logic [7:0] CYCLE_CLK_RESET = 8'h00;
  localparam logic [1:0] LAYOUT_RESET = 2'h0;
  localparam logic [2:0] POLICY_RESET = 3'h1;
  localparam logic [3:0] SUM_KEY_RESET = 4'h0;

  localparam logic [7:0] HS_MIN_CLOCKS = 8'h15;
  localparam logic [7:0] LP_MIN_CLOCKS = 8'h12;

  localparam logic [2:0] POLICY_STOP_BURST = 3'h0;
  localparam logic [2:0] POLICY_START_BURST = 3'h1;
  localparam logic [2:0] POLICY_PRE_ALERT = 3'h4;
  localparam logic [2:0] POLICY_POST_ALERT = 3'h6;

  localparam logic [3:0] SUM_KEY_OFF = 4'h0;
  localparam logic [3:0] SUM_KEY_ON = 4'hF;

  localparam logic [4:0] BUFFER_DEPTH = 5'h10;
  localparam logic [3:0] ZERO_NIBBLE = 4'h0;

  typedef enum logic [1:0]
  {
    LAYOUT_PLAIN = 2'b00,
    LAYOUT_CHAN_ID = 2'b01,
    LAYOUT_CHAN_VALID = 2'b10,
    LAYOUT_PLAIN_ALT = 2'b11
  } word_layout_t;

  typedef struct packed
  {
    logic strobe;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed
  {
    logic valid;
    logic chan;
    logic [11:0] value;
  } conv_result_t;
endpackage : conv_regs_pkg
`default_nettype wire

// >>> verilog/conversion_buffer_accum_regs.sv
// Converter timing, buffer-format and accumulator register bank
// Contract
// - Choice bit selects high speed or low power
// - Conversion lasts programmed clocks of selected oscillator
// - High speed codes below 21 give 21
// - Low power codes below 18 give 18
// - Fill policy codes stop, start, pre, post
// - Fill policy resets to start burst
// - Each buffer entry is a 16-bit word
// - Layouts 00, 11: result then four zeros
// - Layout 01: result then channel id
// - Layout 10: result, channel id, valid flag
// - Read-only count of filled buffer entries
// - Counts and sums clear on reset or kick
// - Summing key 0000 off, 1111 on
// - Channel sums as low/high byte registers
// - Read-only tally of completed accumulations
// - Sequence kick raises scan-active and starts conversion
`default_nettype none
module conversion_buffer_accum_regs
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire conv_regs_pkg::reg_req_t req,
  output logic [7:0] rdata,
  input wire logic general_call_reset,
  input wire logic device_reset,
  input wire conv_regs_pkg::conv_result_t result,
  input wire logic buffer_push,
  input wire logic scan_done,
  output logic oscillator_choice,
  output logic [7:0] cycle_clocks,
  output logic [2:0] buffer_fill_policy,
  output logic [15:0] buffer_word,
  output logic buffer_word_valid,
  output logic scan_active,
  output logic conversion_start
);
  import conv_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic osc_reg;
  logic [7:0] cycle_clock_setting_reg;
  logic [1:0] layout_reg;
  logic [2:0] policy_reg;
  logic [3:0] summing_enable_key_reg;
  logic [4:0] filled_entry_count_reg;
  logic [3:0] summation_tally_reg;
  logic [15:0] chan0_sum_reg;
  logic [15:0] chan1_sum_reg;
  logic scan_reg;
  logic start_reg;
  logic [15:0] word_reg;
  logic word_valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of byte-wide accesses
  wire wr = req.strobe && req.write;
  wire wr_osc = wr && (req.addr == ADDR_OSC_CHOICE);
  wire wr_cycle = wr && (req.addr == ADDR_CYCLE_CLK);
  wire wr_layout = wr && (req.addr == ADDR_WORD_LAYOUT);
  wire wr_policy = wr && (req.addr == ADDR_FILL_POLICY);
  wire wr_sum = wr && (req.addr == ADDR_SUM_ENABLE);
  wire kick = wr && (req.addr == ADDR_SEQ_KICK) && req.wdata[0];
  // Any of these empties the status and sums
  wire status_clear = general_call_reset || device_reset || kick;

  // Reserved policy codes are dropped so the field always holds a mode
  wire policy_legal = (req.wdata[2:0] == POLICY_STOP_BURST)
    || (req.wdata[2:0] == POLICY_START_BURST)
    || (req.wdata[2:0] == POLICY_PRE_ALERT)
    || (req.wdata[2:0] == POLICY_POST_ALERT);
  // Reserved key codes are likewise dropped
  wire key_legal = (req.wdata[3:0] == SUM_KEY_OFF)
    || (req.wdata[3:0] == SUM_KEY_ON);
  wire summing_on = summing_enable_key_reg == SUM_KEY_ON;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle length: floor depends on the selected oscillator
  wire [7:0] clock_floor = osc_reg ? LP_MIN_CLOCKS : HS_MIN_CLOCKS;
  assign cycle_clocks = (cycle_clock_setting_reg < clock_floor)
    ? clock_floor : cycle_clock_setting_reg;
  assign oscillator_choice = osc_reg;
  assign buffer_fill_policy = policy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Buffer word formatting
  wire [2:0] chan_id = {2'b00, result.chan};
  word_layout_t layout;
  assign layout = word_layout_t'(layout_reg);
  logic [15:0] word_next;
  always_comb
  begin
    unique case (layout)
      LAYOUT_CHAN_ID: word_next = {result.value, chan_id, 1'b0};
      LAYOUT_CHAN_VALID:
        word_next = {result.value, chan_id, result.valid};
      LAYOUT_PLAIN, LAYOUT_PLAIN_ALT:
        word_next = {result.value, ZERO_NIBBLE};
    endcase
  end

  wire push_ok = buffer_push && (filled_entry_count_reg < BUFFER_DEPTH);
  wire [15:0] sum0_next = chan0_sum_reg + {4'h0, result.value};
  wire [15:0] sum1_next = chan1_sum_reg + {4'h0, result.value};
  wire do_sum = result.valid && summing_on;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      osc_reg <= 1'b0;
      cycle_clock_setting_reg <= CYCLE_CLK_RESET;
      layout_reg <= LAYOUT_RESET;
      policy_reg <= POLICY_RESET;
      summing_enable_key_reg <= SUM_KEY_RESET;
    end
    else if (clk_en)
    begin
      if (wr_osc)
        osc_reg <= req.wdata[0];
      if (wr_cycle)
        cycle_clock_setting_reg <= req.wdata;
      if (wr_layout)
        layout_reg <= req.wdata[1:0];
      if (wr_policy && policy_legal)
        policy_reg <= req.wdata[2:0];
      if (wr_sum && key_legal)
        summing_enable_key_reg <= req.wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, sums and buffer word
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      filled_entry_count_reg <= 5'h00;
      summation_tally_reg <= 4'h0;
      chan0_sum_reg <= 16'h0000;
      chan1_sum_reg <= 16'h0000;
      word_reg <= 16'h0000;
      word_valid_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      word_valid_reg <= push_ok;
      if (push_ok)
        word_reg <= word_next;
      if (status_clear)
      begin
        filled_entry_count_reg <= 5'h00;
        summation_tally_reg <= 4'h0;
        chan0_sum_reg <= 16'h0000;
        chan1_sum_reg <= 16'h0000;
      end
      else
      begin
        if (push_ok)
          filled_entry_count_reg <= filled_entry_count_reg + 5'h01;
        if (do_sum)
        begin
          summation_tally_reg <= summation_tally_reg + 4'h1;
          if (result.chan)
            chan1_sum_reg <= sum1_next;
          else
            chan0_sum_reg <= sum0_next;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan activity
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      scan_reg <= 1'b0;
      start_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      start_reg <= kick;
      if (kick)
        scan_reg <= 1'b1;
      else if (scan_done || device_reset || general_call_reset)
        scan_reg <= 1'b0;
    end
  end
  assign scan_active = scan_reg;
  assign conversion_start = start_reg;
  assign buffer_word = word_reg;
  assign buffer_word_valid = word_valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits and unmapped bytes read as zero
  always_comb
  begin
    unique case (req.addr)
      ADDR_FILL_COUNT: rdata = {3'h0, filled_entry_count_reg};
      ADDR_TALLY: rdata = {4'h0, summation_tally_reg};
      ADDR_C0_LOW: rdata = chan0_sum_reg[7:0];
      ADDR_C0_HIGH: rdata = chan0_sum_reg[15:8];
      ADDR_C1_LOW: rdata = chan1_sum_reg[7:0];
      ADDR_C1_HIGH: rdata = chan1_sum_reg[15:8];
      ADDR_OSC_CHOICE: rdata = {7'h00, osc_reg};
      ADDR_CYCLE_CLK: rdata = cycle_clock_setting_reg;
      ADDR_WORD_LAYOUT: rdata = {6'h00, layout_reg};
      ADDR_FILL_POLICY: rdata = {5'h00, policy_reg};
      ADDR_SUM_ENABLE: rdata = {4'h0, summing_enable_key_reg};
      default: rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Steps named for the properties below; sum_taken and kick_taken serve several
  sequence push_taken;
    clk_en && push_ok && !status_clear;
  endsequence
  sequence sum_taken;
    clk_en && do_sum && !status_clear;
  endsequence
  sequence kick_taken;
    clk_en && kick;
  endsequence
  sequence kick_quiet;
    clk_en && !kick;
  endsequence
  a_policy_reset: assert property (@(posedge clock)
    $fell(rst) |-> policy_reg == POLICY_START_BURST)
    else $error("fill policy not start burst after reset");
  a_hs_floor: assert property (@(posedge clock) disable iff (rst)
    !osc_reg && cycle_clock_setting_reg <= HS_MIN_CLOCKS
      |-> cycle_clocks == HS_MIN_CLOCKS)
    else $error("high speed cycle floor wrong");
  a_lp_floor: assert property (@(posedge clock) disable iff (rst)
    osc_reg && cycle_clock_setting_reg <= LP_MIN_CLOCKS
      |-> cycle_clocks == LP_MIN_CLOCKS)
    else $error("low power cycle floor wrong");
  a_lp_pass: assert property (@(posedge clock) disable iff (rst)
    osc_reg && cycle_clock_setting_reg > LP_MIN_CLOCKS
      |-> cycle_clocks == cycle_clock_setting_reg)
    else $error("low power cycle count not passed through");
  a_cycle_pass: assert property (@(posedge clock) disable iff (rst)
    cycle_clock_setting_reg > HS_MIN_CLOCKS
      |-> cycle_clocks == cycle_clock_setting_reg)
    else $error("cycle count not passed through");
  a_osc_read: assert property (@(posedge clock) disable iff (rst)
    req.addr == ADDR_OSC_CHOICE |-> rdata == {7'h00, oscillator_choice})
    else $error("oscillator choice reads back wrong");

  // Clearing is a restart, so it beats a push or sum in the same cycle
  a_kick_clears: assert property (@(posedge clock) disable iff (rst)
    kick_taken |=> filled_entry_count_reg == 5'h00
      && summation_tally_reg == 4'h0 && chan0_sum_reg == 16'h0000)
    else $error("kick did not clear status");
  a_reset_clears: assert property (@(posedge clock) disable iff (rst)
    clk_en && !kick && (general_call_reset || device_reset)
      |=> filled_entry_count_reg == 5'h00 && summation_tally_reg == 4'h0
      && chan0_sum_reg == 16'h0000 && chan1_sum_reg == 16'h0000
      && !scan_active)
    else $error("reset request did not clear status");
  a_kick_scan: assert property (@(posedge clock) disable iff (rst)
    kick_taken |=> scan_active && conversion_start)
    else $error("kick did not start scan");
  a_start_pulse: assert property (@(posedge clock) disable iff (rst)
    kick_taken ##1 kick_quiet |=> !conversion_start)
    else $error("conversion start held too long");
  a_scan_done: assert property (@(posedge clock) disable iff (rst)
    clk_en && !kick && scan_done |=> !scan_active)
    else $error("scan did not end");

  a_count_cap: assert property (@(posedge clock) disable iff (rst)
    filled_entry_count_reg <= BUFFER_DEPTH)
    else $error("fill count above depth");
  a_count_step: assert property (@(posedge clock) disable iff (rst)
    push_taken |=> filled_entry_count_reg
      == $past(filled_entry_count_reg) + 5'h01)
    else $error("fill count did not step");
  // A full buffer drops the entry rather than overwrite the oldest
  a_full_hold: assert property (@(posedge clock) disable iff (rst)
    clk_en && buffer_push && !status_clear
      && filled_entry_count_reg == BUFFER_DEPTH
      |=> filled_entry_count_reg == BUFFER_DEPTH && !buffer_word_valid)
    else $error("push taken into full buffer");
  a_tally_step: assert property (@(posedge clock) disable iff (rst)
    sum_taken |=> summation_tally_reg
      == $past(summation_tally_reg) + 4'h1)
    else $error("tally did not step");
  a_sum0_add: assert property (@(posedge clock) disable iff (rst)
    sum_taken ##0 !result.chan |=> chan0_sum_reg
      == $past(chan0_sum_reg) + {4'h0, $past(result.value)})
    else $error("channel 0 sum did not add");
  a_sum1_add: assert property (@(posedge clock) disable iff (rst)
    sum_taken ##0 result.chan |=> chan1_sum_reg
      == $past(chan1_sum_reg) + {4'h0, $past(result.value)})
    else $error("channel 1 sum did not add");
  a_key_legal: assert property (@(posedge clock) disable iff (rst)
    summing_enable_key_reg == SUM_KEY_OFF
      || summing_enable_key_reg == SUM_KEY_ON)
    else $error("summing key holds reserved code");
  a_sum_off: assert property (@(posedge clock) disable iff (rst)
    clk_en && !summing_on && !status_clear
      |=> $stable(summation_tally_reg) && $stable(chan0_sum_reg))
    else $error("sums moved while summing off");
  a_policy_legal: assert property (@(posedge clock) disable iff (rst)
    policy_reg == POLICY_STOP_BURST || policy_reg == POLICY_START_BURST
      || policy_reg == POLICY_PRE_ALERT || policy_reg == POLICY_POST_ALERT)
    else $error("fill policy holds reserved code");

  a_word_valid: assert property (@(posedge clock) disable iff (rst)
    clk_en && push_ok |=> buffer_word_valid)
    else $error("accepted push gave no word");
  a_plain_word: assert property (@(posedge clock) disable iff (rst)
    clk_en && push_ok
      && (layout_reg == LAYOUT_PLAIN || layout_reg == LAYOUT_PLAIN_ALT)
      |=> buffer_word == {$past(result.value), ZERO_NIBBLE})
    else $error("plain layout word wrong");
  a_id_word: assert property (@(posedge clock) disable iff (rst)
    clk_en && push_ok && layout_reg == LAYOUT_CHAN_ID
      |=> buffer_word[15:4] == $past(result.value)
      && buffer_word[3:0] == {2'b00, $past(result.chan), 1'b0})
    else $error("channel id layout word wrong");
  a_flag_word: assert property (@(posedge clock) disable iff (rst)
    clk_en && push_ok && layout_reg == LAYOUT_CHAN_VALID
      |=> buffer_word[15:4] == $past(result.value)
      && buffer_word[3:0] == {2'b00, $past(result.chan), $past(result.valid)})
    else $error("flagged layout word wrong");

  // Low clock enable must freeze every register, host writes included
  a_freeze: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(policy_reg) && $stable(filled_entry_count_reg)
      && $stable(scan_reg) && $stable(word_valid_reg))
    else $error("state moved while clock enable low");
  a_ro_write: assert property (@(posedge clock) disable iff (rst)
    wr && req.addr == ADDR_FILL_COUNT && !buffer_push && !status_clear
      |=> $stable(filled_entry_count_reg))
    else $error("write changed read-only count");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (rst)
    req.addr == ADDR_SEQ_KICK |-> rdata == 8'h00)
    else $error("write-only kick byte reads nonzero");
endmodule : conversion_buffer_accum_regs
`default_nettype wire

// >>> dv/host_model.sv
// Host-side model issuing byte-wide register requests
`default_nettype none
module host_model
  import conv_regs_pkg::*;
(
  input wire logic clock,
  output var conv_regs_pkg::reg_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // Data is inverted once released so a late sample cannot pass
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{1'b1, 1'b1, a, d};
    @(posedge clock);
    req <= '{1'b0, 1'b0, a, ~d};
  endtask : write_reg
  task automatic point_at(input logic [7:0] a);
    @(posedge clock);
    req <= '{1'b0, 1'b0, a, req.wdata};
  endtask : point_at
endmodule : host_model
`default_nettype wire

// >>> dv/test_conversion_buffer_accum_regs.sv
// Self-checking bench for the converter register bank
`default_nettype none
module test_conversion_buffer_accum_regs;
  import conv_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [1:0] kind; logic [15:0] val;} note_t;
  logic clock;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic general_call_reset = 1'b0;
  logic device_reset = 1'b0;
  logic buffer_push = 1'b0;
  logic scan_done = 1'b0;
  logic oscillator_choice, buffer_word_valid, scan_active, conversion_start;
  logic [7:0] rdata, cycle_clocks, c;
  logic [2:0] buffer_fill_policy;
  logic [2:0] pol = 3'h1;
  logic [15:0] buffer_word;
  logic [15:0] sum0 = '0;
  logic [15:0] sum1 = '0;
  logic [11:0] v;
  logic [3:0] key = '0;
  logic [3:0] tally = '0;
  logic [4:0] fill = '0;
  logic osc, ch;
  reg_req_t req;
  conv_result_t result = '0;
  note_t notes[$];
  logic [15:0] words[$];
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 67;
  // Unmapped 55h sits before the policy so only the last entry reads 01
  logic [7:0] addrs[11] = '{ADDR_FILL_COUNT, ADDR_TALLY, ADDR_C0_LOW,
    ADDR_C0_HIGH, ADDR_C1_LOW, ADDR_C1_HIGH, ADDR_CYCLE_CLK,
    ADDR_WORD_LAYOUT, ADDR_SUM_ENABLE, 8'h55, ADDR_FILL_POLICY};
  logic [7:0] codes[7] = '{8'h00, 8'h12, 8'h13, 8'h15, 8'h16, 8'hFF, 8'h00};

  conversion_buffer_accum_regs u_conversion_buffer_accum_regs (
    .clock, .rst, .clk_en, .req, .rdata, .general_call_reset,
    .device_reset, .result, .buffer_push, .scan_done, .oscillator_choice,
    .cycle_clocks, .buffer_fill_policy, .buffer_word, .buffer_word_valid,
    .scan_active, .conversion_start);
  host_model u_host_model (.clock, .req);

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test();
    if (fail_count == 0 && cmp_count > 0 && words.size() == 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // Notes are due at the next falling edge
  task automatic note(input logic [1:0] k, input logic [15:0] e);
    notes.push_back('{k, e});
  endtask : note
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_host_model.point_at(a);
    note(2'd0, {8'h00, e});
  endtask : rd
  task automatic push(input logic [1:0] lay);
    v = 12'($random(seed));
    ch = 1'($random(seed));
    @(posedge clock);
    result <= '{1'b1, ch, v};
    buffer_push <= 1'b1;
    // A full buffer drops the push, so no word is owed for it
    if (fill < 5'd16)
      case (lay)
        2'd1: words.push_back({v, 2'b00, ch, 1'b0});
        2'd2: words.push_back({v, 2'b00, ch, 1'b1});
        default: words.push_back({v, 4'h0});
      endcase
    if (key == 4'hF && ch)
      sum1 += 16'(v);
    else if (key == 4'hF)
      sum0 += 16'(v);
    if (key == 4'hF)
      tally++;
    if (fill < 5'd16)
      fill++;
    @(posedge clock);
    result <= '{1'b0, ~ch, ~v};
    buffer_push <= 1'b0;
  endtask : push
  task automatic pulse(input int k);
    @(posedge clock);
    if (k == 1)
      general_call_reset <= 1'b1;
    else
      device_reset <= 1'b1;
    @(posedge clock);
    general_call_reset <= 1'b0;
    device_reset <= 1'b0;
  endtask : pulse
  ////////////////////////////////////////////////////////////
  always @(negedge clock)
  begin : watch
    note_t n;
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      case (n.kind)
        2'd0: check({8'h00, rdata}, n.val);
        2'd1: check({8'h00, cycle_clocks}, n.val);
        2'd2: check({13'h0000, buffer_fill_policy}, n.val);
        default: check({13'h0000, oscillator_choice, scan_active,
          conversion_start}, n.val);
      endcase
    end
    if (buffer_word_valid === 1'b1)
      check(buffer_word, words.size() ? words.pop_front() : 16'hXXXX);
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fail_count++;
      finish_test();
    end
  end

  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++)
      rd(addrs[i], (i == 10) ? 8'h01 : 8'h00);
    note(2'd2, 16'h0001);
    codes[6] = 8'($random(seed));
    for (int o = 0; o < 2; o++)
    begin
      osc = o[0];
      u_host_model.write_reg(ADDR_OSC_CHOICE, {7'h7F, osc});
      rd(ADDR_OSC_CHOICE, {7'h00, osc});
      note(2'd3, {13'h0000, osc, 2'b00});
      foreach (codes[k])
      begin
        c = codes[k];
        u_host_model.write_reg(ADDR_CYCLE_CLK, c);
        note(2'd1, {8'h00, osc ? ((c < 8'h12) ? 8'h12 : c)
          : ((c < 8'h15) ? 8'h15 : c)});
        rd(ADDR_CYCLE_CLK, c);
      end
    end
    for (int i = 0; i < 8; i++)
    begin
      u_host_model.write_reg(ADDR_FILL_POLICY, {5'h1F, 3'(i)});
      if (i == 0 || i == 1 || i == 4 || i == 6)
        pol = 3'(i);
      note(2'd2, {13'h0000, pol});
      rd(ADDR_FILL_POLICY, {5'h00, pol});
    end
    for (int i = 0; i < 16; i++)
    begin
      u_host_model.write_reg(ADDR_SUM_ENABLE, {4'hF, 4'(i)});
      if (i == 0 || i == 15)
        key = 4'(i);
      rd(ADDR_SUM_ENABLE, {4'h0, key});
    end
    // A write while frozen must leave the policy alone
    @(posedge clock);
    clk_en <= 1'b0;
    u_host_model.write_reg(ADDR_FILL_POLICY, 8'h00);
    clk_en <= 1'b1;
    rd(ADDR_FILL_POLICY, {5'h00, pol});
    u_host_model.write_reg(ADDR_SEQ_KICK, 8'h01);
    note(2'd3, {13'h0000, osc, 2'b11});
    @(posedge clock);
    note(2'd3, {13'h0000, osc, 2'b10});
    rd(ADDR_SEQ_KICK, 8'h00);
    scan_done <= 1'b1;
    @(posedge clock);
    scan_done <= 1'b0;
    note(2'd3, {13'h0000, osc, 2'b00});
    // Seventeen pushes run one past the buffer depth
    for (int j = 0; j < 17; j++)
    begin
      u_host_model.write_reg(ADDR_WORD_LAYOUT, {6'h3F, 2'(j)});
      push(2'(j));
    end
    rd(ADDR_FILL_COUNT, {3'h0, fill});
    rd(ADDR_TALLY, {4'h0, tally});
    rd(ADDR_C0_LOW, sum0[7:0]);
    rd(ADDR_C0_HIGH, sum0[15:8]);
    rd(ADDR_C1_LOW, sum1[7:0]);
    rd(ADDR_C1_HIGH, sum1[15:8]);
    u_host_model.write_reg(ADDR_C0_LOW, 8'hA5);
    u_host_model.write_reg(ADDR_FILL_COUNT, 8'hA5);
    rd(ADDR_C0_LOW, sum0[7:0]);
    rd(ADDR_FILL_COUNT, {3'h0, fill});
    for (int r = 0; r < 3; r++)
    begin
      push(2'd0);
      if (r == 0)
        u_host_model.write_reg(ADDR_SEQ_KICK, 8'h01);
      else
        pulse(r);
      fill = '0;
      tally = '0;
      sum0 = '0;
      sum1 = '0;
      for (int i = 0; i < 6; i++)
        rd(addrs[i], 8'h00);
      note(2'd3, {13'h0000, osc, (r == 0), 1'b0});
    end
    finish_test();
  end
endmodule : test_conversion_buffer_accum_regs
`default_nettype wire
